// ### dv/alcv_src.sv
`timescale 1ns/1ps
module alcv_src (
    // Clock
    input wire logic pclk,
    // Samples towards the block
    output logic sample_valid,
    output logic signed [15:0] sample_in,
    // Samples from the block
    input wire logic sample_out_valid,
    input wire logic signed [15:0] sample_out
);
    initial begin
        sample_valid = 1'b0;
        sample_in = 16'h0000;
    end

    // One sample strobe, then an idle gap of gap cycles
    task automatic push(input logic signed [15:0] x, input int gap,
            output logic signed [15:0] y, output logic ok);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_in <= x;
        @(posedge pclk);
        sample_valid <= 1'b0;
        // Released data must not look like the last sample
        sample_in <= ~x;
        #1;
        ok = sample_out_valid;
        y = sample_out;
        repeat (gap) @(posedge pclk);
    endtask
endmodule

// ### dv/tb_auto_level_control_volume.sv
`timescale 1ns/1ps
module tb_auto_level_control_volume import alcv_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sample_valid;
    logic sample_out_valid;
    logic signed [15:0] sample_in;
    logic signed [15:0] sample_out;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] r;
    logic e;
    logic ok;
    logic signed [15:0] y;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] din;
        logic [15:0] dout;
    } alcv_row_s;
    alcv_row_s rows [5] = '{'{32'h01, 16'h4000, 16'h4000},
        '{32'h11, 16'h4000, 16'h2000}, '{32'h21, 16'h4000, 16'h1000},
        '{32'h31, 16'h4000, 16'h0800}, '{32'h31, 16'hC000, 16'hF800}};
    logic [31:0] dflt [5] = '{32'h01, 32'h001, 32'h28C5, 32'h91, 32'h06E};

    always #5 pclk = ~pclk;

    alcv_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_in(sample_in), .sample_out_valid(sample_out_valid),
        .sample_out(sample_out));

    alcv_src i_src (.pclk(pclk), .sample_valid(sample_valid),
        .sample_in(sample_in), .sample_out_valid(sample_out_valid),
        .sample_out(sample_out));

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] ex,
            input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_smp(input string nm, input logic [15:0] ex,
            input logic [15:0] got);
        cmp_count++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic gain_is(input string nm, input logic [7:0] ex);
        apb(1'b0, ALCV_OFF_STATUS, 32'h0);
        chk_reg(nm, {24'h0, ex}, {24'h0, r[7:0]});
    endtask

    // Small alternating samples, well under every reset band
    task automatic quiet(input int n);
        for (int i = 0; i < n; i++) begin
            i_src.push(i[0] ? 16'sh0100 : -16'sh0100, i % 4, y, ok);
        end
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, ALCV_OFF_CTRL, rows[i].ctrl);
            i_src.push(rows[i].din, i % 3, y, ok);
            chk_reg("out_valid", 32'h1, {31'h0, ok});
            chk_smp("post_att", rows[i].dout, y);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk_smp("out_reset", 16'h0000, sample_out);
        apb(1'b1, ALCV_OFF_STATUS, 32'hFFFF);
        // Clock enable low: the sample must not be taken
        ce <= 1'b0;
        i_src.push(16'h1234, 0, y, ok);
        chk_reg("ce_frozen", 32'h0, {31'h0, ok});
        chk_smp("ce_hold", 16'h0000, y);
        @(posedge pclk);
        ce <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_reg("default", dflt[i], r);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk_reg("unmapped_err", 32'h1, {31'h0, e});
        // Settings only while both enables are clear
        apb(1'b1, ALCV_OFF_REF, 32'h2891);
        apb(1'b1, ALCV_OFF_LIMIT, 32'h10D);
        apb(1'b1, ALCV_OFF_CTRL, 32'h0A);
        i_src.push(16'h7000, 0, y, ok);
        apb(1'b0, ALCV_OFF_STATUS, 32'h0);
        chk_reg("other_path", 32'h06E, r);
        apb(1'b1, ALCV_OFF_CTRL, 32'h0B);
        i_src.push(16'h7000, 2, y, ok);
        chk_smp("first_hit", 16'h7000, y);
        gain_is("one_step", 8'h6F);
        i_src.push(16'h7000, 0, y, ok);
        gain_is("repeat_step", 8'h70);
        quiet(100);
        gain_is("still_waiting", 8'h70);
        quiet(60);
        gain_is("recovered", 8'h6E);
        quiet(200);
        gain_is("at_ceiling", 8'h6E);
        i_src.push(16'h4800, 0, y, ok);
        gain_is("below_det", 8'h6E);
        // Zero-cross gated limiting, steps 2/4/4/8, fast recovery 8x
        apb(1'b1, ALCV_OFF_CTRL, 32'h01);
        apb(1'b1, ALCV_OFF_LIMIT, 32'h409);
        apb(1'b1, ALCV_OFF_CTRL, 32'h03);
        i_src.push(-16'sh0100, 0, y, ok);
        i_src.push(16'sh8000, 0, y, ok);
        apb(1'b0, ALCV_OFF_STATUS, 32'h0);
        chk_reg("zc_pending", 32'h76E, r);
        i_src.push(16'sh0100, 0, y, ok);
        gain_is("zc_applied", 8'h72);
        quiet(20);
        gain_is("fast_step", 8'h71);
        quiet(64);
        apb(1'b0, ALCV_OFF_STATUS, 32'h0);
        chk_reg("fast_done", 32'h36E, r);
        // Switch-off returns to manual gain only after the timeout
        apb(1'b1, ALCV_OFF_MANUAL, 32'h85);
        apb(1'b1, ALCV_OFF_CTRL, 32'h01);
        quiet(100);
        gain_is("leaving", 8'h6E);
        quiet(40);
        gain_is("manual_back", 8'h7A);
        final_report();
    end
endmodule

// ### logic/alcv_pkg.sv
package alcv_pkg;
    // Register offsets
    localparam logic [7:0] ALCV_OFF_CTRL = 8'h00;
    localparam logic [7:0] ALCV_OFF_LIMIT = 8'h04;
    localparam logic [7:0] ALCV_OFF_REF = 8'h08;
    localparam logic [7:0] ALCV_OFF_MANUAL = 8'h0C;
    localparam logic [7:0] ALCV_OFF_STATUS = 8'h10;
    // Reset values
    localparam logic ALCV_RST_PATH_REC = 1'b1;
    localparam logic [1:0] ALCV_RST_THR = 2'h1;
    localparam logic [7:0] ALCV_RST_RCEIL = 8'hC5;
    localparam logic [5:0] ALCV_RST_PCEIL = 6'h28;
    localparam logic [7:0] ALCV_RST_MANUAL = 8'h91;
    localparam logic [7:0] ALCV_RST_GAIN = 8'h6E;
    // Gain code ends
    localparam logic [7:0] ALCV_GAIN_MAX = 8'h0E;
    localparam logic [7:0] ALCV_GAIN_MUTE = 8'hFF;
    localparam logic [7:0] ALCV_PCEIL_TOP = 8'hFE;
    // Timeout and wait base, in samples
    localparam logic [10:0] ALCV_PERIOD_BASE = 11'h080;
    // Levels against 16-bit full scale
    localparam logic [23:0] ALCV_LVL_2P5 = 24'h005FE3;
    localparam logic [23:0] ALCV_LVL_4P1 = 24'h004FC2;
    localparam logic [23:0] ALCV_LVL_6P0 = 24'h004027;
    localparam logic [23:0] ALCV_LVL_8P5 = 24'h00301D;
    localparam logic [23:0] ALCV_LVL_12 = 24'h002027;
    localparam logic [23:0] ALCV_LVL_FS = 24'h008000;
    localparam logic [23:0] ALCV_LVL_FS6 = 24'h00FF65;
    localparam logic [23:0] ALCV_LVL_FS12 = 24'h01FD92;
    // 0.375 dB mantissas, Q15
    localparam logic [15:0] ALCV_MANT [16] = '{
        16'h8000, 16'h7A97, 16'h756D, 16'h7073, 16'h6BB3, 16'h6726,
        16'h62CA, 16'h5E9E, 16'h5A9E, 16'h56CA, 16'h531F, 16'h4F9C,
        16'h4C3F, 16'h4906, 16'h45F0, 16'h42FC};
    typedef enum logic [2:0] {
        ALCV_ST_MANUAL = 3'b001,
        ALCV_ST_ACTIVE = 3'b010,
        ALCV_ST_LEAVING = 3'b100
    } alcv_state_e;
endpackage

// ### logic/alcv_top.sv
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module alcv_top import alcv_pkg::*; (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sample stream
    input wire logic sample_valid,
    input wire logic signed [15:0] sample_in,
    output logic sample_out_valid,
    output logic signed [15:0] sample_out
);
    typedef struct packed {
        alcv_state_e st;
        logic path_select_record;
        logic record_level_ctrl_en;
        logic playback_level_ctrl_en;
        logic limiter_zero_cross_disable;
        logic [1:0] post_attenuation_sel;
        logic [1:0] limiter_threshold_sel;
        logic [1:0] limiter_step_sel;
        logic [1:0] zero_cross_timeout_sel;
        logic [1:0] recovery_wait_sel;
        logic [1:0] recovery_step_sel;
        logic [1:0] fast_recovery_speed_sel;
        logic [7:0] record_gain_ceiling;
        logic [5:0] playback_gain_ceiling;
        logic [7:0] manual_output_gain;
        logic [7:0] gain;
        logic [10:0] zc_cnt;
        logic [10:0] wait_cnt;
        logic [3:0] pend_att;
        logic [2:0] pend_rec;
        logic fast;
        logic prev_neg;
        logic out_valid;
        logic [15:0] out;
        logic [31:0] rdata;
    } alcv_regs_s;

    alcv_regs_s s;
    alcv_regs_s n;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == ALCV_OFF_CTRL) || (a == ALCV_OFF_LIMIT) ||
            (a == ALCV_OFF_REF) || (a == ALCV_OFF_MANUAL) ||
            (a == ALCV_OFF_STATUS);
    endfunction

    // Scale by gain code: +36 dB at 0EH, 16 steps per octave
    function automatic logic signed [39:0] gain_apply(
        input logic signed [15:0] x, input logic [7:0] c);
        logic [7:0] a;
        logic signed [39:0] p;
        a = c - ALCV_GAIN_MAX;
        p = $signed({{24{x[15]}}, x}) * $signed({24'h0, ALCV_MANT[a[3:0]]});
        gain_apply = (c == ALCV_GAIN_MUTE) ? 40'sh0 :
            (p >>> ({1'b0, a[7:4]} + 5'h09));
    endfunction

    function automatic logic [7:0] gain_down(input logic [7:0] g,
        input logic [3:0] st);
        logic [8:0] sum;
        sum = {1'b0, g} + {5'h00, st};
        gain_down = sum[8] ? ALCV_GAIN_MUTE : sum[7:0];
    endfunction

    function automatic logic [7:0] gain_up(input logic [7:0] g,
        input logic [2:0] st, input logic [7:0] ceil);
        logic [8:0] d;
        d = {1'b0, g} - {6'h00, st};
        if (g <= ceil) begin
            gain_up = g;
        end else if (d[8] || d[7:0] < ceil) begin
            gain_up = ceil;
        end else begin
            gain_up = d[7:0];
        end
    endfunction

    logic en;
    logic strobe;
    logic signed [39:0] wide;
    logic [39:0] mag40;
    logic [23:0] mag;
    logic [23:0] det_lvl;
    logic [23:0] rst_lvl;
    logic lim_hit;
    logic quiet;
    logic [1:0] band;
    logic [3:0] lim_step;
    logic zc_now;
    logic [10:0] zc_to;
    logic [10:0] wait_to;
    logic to_hit;
    logic [7:0] ceil_live;
    logic [7:0] manual_live;
    logic [7:0] pceil_x4;
    logic signed [15:0] clipped;
    logic setup;
    logic access;

    always_comb begin
        en = s.path_select_record ? s.record_level_ctrl_en
            : s.playback_level_ctrl_en;
        strobe = sample_valid && ce;
        wide = gain_apply(sample_in, s.gain);
        mag40 = wide[39] ? -wide : wide;
        mag = (mag40 > 40'h0000FFFFFF) ? 24'hFFFFFF : mag40[23:0];
        case (s.limiter_threshold_sel)
            2'h0: begin
                det_lvl = ALCV_LVL_2P5;
                rst_lvl = ALCV_LVL_4P1;
            end
            2'h1: begin
                det_lvl = ALCV_LVL_4P1;
                rst_lvl = ALCV_LVL_6P0;
            end
            2'h2: begin
                det_lvl = ALCV_LVL_6P0;
                rst_lvl = ALCV_LVL_8P5;
            end
            default: begin
                det_lvl = ALCV_LVL_8P5;
                rst_lvl = ALCV_LVL_12;
            end
        endcase
        lim_hit = mag >= det_lvl;
        quiet = mag < rst_lvl;
        band = (mag >= ALCV_LVL_FS12) ? 2'h3 : (mag >= ALCV_LVL_FS6) ? 2'h2 :
            (mag >= ALCV_LVL_FS) ? 2'h1 : 2'h0;
        case (s.limiter_step_sel)
            2'h0: lim_step = 4'h1;
            2'h1: lim_step = 4'h2;
            2'h2: lim_step = (band == 2'h0) ? 4'h2 :
                (band == 2'h3) ? 4'h8 : 4'h4;
            default: lim_step = (band == 2'h0) ? 4'h1 :
                (band == 2'h1) ? 4'h2 : (band == 2'h2) ? 4'h4 : 4'h8;
        endcase
        zc_now = (wide == 40'sh0) || (wide[39] != s.prev_neg);
        zc_to = ALCV_PERIOD_BASE << s.zero_cross_timeout_sel;
        wait_to = ALCV_PERIOD_BASE << s.recovery_wait_sel;
        if (s.fast) begin
            case (s.fast_recovery_speed_sel)
                2'h1: wait_to = wait_to >> 3;
                2'h2: wait_to = wait_to >> 4;
                default: wait_to = wait_to >> 2;
            endcase
        end
        to_hit = (s.zc_cnt + 11'h001) >= zc_to;
        manual_live = ALCV_GAIN_MUTE - s.manual_output_gain;
        // Codes above the top setting would wrap past maximum gain
        if (manual_live < ALCV_GAIN_MAX) begin
            manual_live = ALCV_GAIN_MAX;
        end
        pceil_x4 = {s.playback_gain_ceiling, 2'b00};
        if (s.path_select_record) begin
            ceil_live = ALCV_GAIN_MUTE - s.record_gain_ceiling;
        end else begin
            ceil_live = ALCV_PCEIL_TOP - pceil_x4;
        end
        if (ceil_live < ALCV_GAIN_MAX) begin
            ceil_live = ALCV_GAIN_MAX;
        end
        clipped = (wide > 40'sh0000007FFF) ? 16'sh7FFF :
            (wide < -40'sh0000008000) ? -16'sh8000 : wide[15:0];
        setup = psel && !penable;
        access = psel && penable;
    end

    always_comb begin
        n = s;
        n.out_valid = 1'b0;
        if (setup) begin
            case (paddr)
                ALCV_OFF_CTRL: n.rdata = {26'h0, s.post_attenuation_sel,
                    s.limiter_zero_cross_disable, s.playback_level_ctrl_en,
                    s.record_level_ctrl_en, s.path_select_record};
                ALCV_OFF_LIMIT: n.rdata = {20'h0, s.fast_recovery_speed_sel,
                    s.recovery_step_sel, s.recovery_wait_sel,
                    s.zero_cross_timeout_sel, s.limiter_step_sel,
                    s.limiter_threshold_sel};
                ALCV_OFF_REF: n.rdata = {18'h0, s.playback_gain_ceiling,
                    s.record_gain_ceiling};
                ALCV_OFF_MANUAL: n.rdata = {24'h0, s.manual_output_gain};
                ALCV_OFF_STATUS: n.rdata = {21'h0, s.fast, en,
                    s.st == ALCV_ST_ACTIVE, s.gain};
                default: n.rdata = 32'h0;
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                ALCV_OFF_CTRL: begin
                    n.path_select_record = pwdata[0];
                    n.record_level_ctrl_en = pwdata[1];
                    n.playback_level_ctrl_en = pwdata[2];
                    n.limiter_zero_cross_disable = pwdata[3];
                    n.post_attenuation_sel = pwdata[5:4];
                end
                ALCV_OFF_LIMIT: begin
                    n.limiter_threshold_sel = pwdata[1:0];
                    n.limiter_step_sel = pwdata[3:2];
                    n.zero_cross_timeout_sel = pwdata[5:4];
                    n.recovery_wait_sel = pwdata[7:6];
                    n.recovery_step_sel = pwdata[9:8];
                    n.fast_recovery_speed_sel = pwdata[11:10];
                end
                ALCV_OFF_REF: begin
                    n.record_gain_ceiling = pwdata[7:0];
                    n.playback_gain_ceiling = pwdata[13:8];
                end
                ALCV_OFF_MANUAL: n.manual_output_gain = pwdata[7:0];
                default: ;
            endcase
        end
        // Entering needs no sample, so the first one is already limited
        if (s.st == ALCV_ST_MANUAL && en) begin
            n.st = ALCV_ST_ACTIVE;
            n.zc_cnt = 11'h000;
            n.wait_cnt = 11'h000;
            n.pend_att = 4'h0;
            n.pend_rec = 3'h0;
            n.fast = 1'b0;
        end
        if (strobe) begin
            n.out_valid = 1'b1;
            n.out = clipped >>> s.post_attenuation_sel;
            n.prev_neg = wide[39];
            case (s.st)
                ALCV_ST_MANUAL: begin
                    n.zc_cnt = 11'h000;
                    n.wait_cnt = 11'h000;
                    n.pend_att = 4'h0;
                    n.pend_rec = 3'h0;
                    n.fast = 1'b0;
                    if (en) begin
                        n.st = ALCV_ST_ACTIVE;
                    end else if (s.gain != manual_live) begin
                        n.zc_cnt = s.zc_cnt + 11'h001;
                        if (zc_now || to_hit) begin
                            n.gain = manual_live;
                            n.zc_cnt = 11'h000;
                        end
                    end
                end
                ALCV_ST_ACTIVE: begin
                    if (!en) begin
                        n.st = ALCV_ST_LEAVING;
                        n.zc_cnt = 11'h000;
                    end else begin
                        if (lim_hit || !quiet) begin
                            n.wait_cnt = 11'h000;
                        end else if (s.wait_cnt != 11'h7FF) begin
                            n.wait_cnt = s.wait_cnt + 11'h001;
                        end
                        if (lim_hit) begin
                            n.pend_rec = 3'h0;
                            if (band != 2'h0) begin
                                n.fast = 1'b1;
                            end
                            if (s.limiter_zero_cross_disable) begin
                                n.gain = gain_down(s.gain, 4'h1);
                                n.pend_att = 4'h0;
                            end else if (lim_step > s.pend_att) begin
                                n.pend_att = lim_step;
                            end
                        end else if (s.pend_att == 4'h0 &&
                            s.pend_rec == 3'h0 &&
                            (s.wait_cnt + 11'h001) >= wait_to) begin
                            n.wait_cnt = 11'h000;
                            if (s.gain > ceil_live) begin
                                n.pend_rec = {1'b0, s.recovery_step_sel}
                                    + 3'h1;
                            end else begin
                                n.fast = 1'b0;
                            end
                        end
                        // Updated requests, so a limiter hit cancels recovery
                        if (n.pend_att != 4'h0 || n.pend_rec != 3'h0) begin
                            n.zc_cnt = s.zc_cnt + 11'h001;
                            if (zc_now || to_hit) begin
                                n.zc_cnt = 11'h000;
                                if (n.pend_att != 4'h0) begin
                                    n.gain = gain_down(s.gain, n.pend_att);
                                    n.wait_cnt = 11'h000;
                                end else begin
                                    n.gain = gain_up(s.gain, n.pend_rec,
                                        ceil_live);
                                end
                                n.pend_att = 4'h0;
                                n.pend_rec = 3'h0;
                            end
                        end else begin
                            n.zc_cnt = 11'h000;
                        end
                    end
                end
                ALCV_ST_LEAVING: begin
                    n.zc_cnt = s.zc_cnt + 11'h001;
                    n.pend_att = 4'h0;
                    n.pend_rec = 3'h0;
                    if (en) begin
                        n.st = ALCV_ST_ACTIVE;
                        n.zc_cnt = 11'h000;
                    end else if (to_hit) begin
                        n.st = ALCV_ST_MANUAL;
                        n.gain = manual_live;
                        n.zc_cnt = 11'h000;
                    end
                end
                default: n.st = ALCV_ST_MANUAL;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= ALCV_ST_MANUAL;
            s.path_select_record <= ALCV_RST_PATH_REC;
            s.limiter_threshold_sel <= ALCV_RST_THR;
            s.record_gain_ceiling <= ALCV_RST_RCEIL;
            s.playback_gain_ceiling <= ALCV_RST_PCEIL;
            s.manual_output_gain <= ALCV_RST_MANUAL;
            s.gain <= ALCV_RST_GAIN;
        end else if (ce) begin
            s <= n;
        end
    end

    assign pready = 1'b1;
    assign prdata = s.rdata;
    assign pslverr = access && !reg_hit(paddr);
    assign sample_out_valid = s.out_valid;
    assign sample_out = s.out;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    gain_range_a: assert property (s.gain >= ALCV_GAIN_MAX)
        else $error("gain code above maximum gain");
    zcd_step_a: assert property (strobe && s.st == ALCV_ST_ACTIVE && en
        && lim_hit && s.limiter_zero_cross_disable && s.gain != 8'hFF
        |=> s.gain == $past(s.gain) + 8'h01)
        else $error("immediate limiter step wrong");
    zc_gate_a: assert property (strobe && s.st == ALCV_ST_ACTIVE && en
        && !s.limiter_zero_cross_disable && !zc_now && !to_hit
        |=> s.gain == $past(s.gain))
        else $error("gain changed without zero crossing");
    lim_prio_a: assert property (strobe && s.st == ALCV_ST_ACTIVE
        && en && lim_hit |=> s.gain >= $past(s.gain))
        else $error("gain raised during limiting");
    ceiling_a: assert property (s.st == ALCV_ST_ACTIVE
        ##1 s.gain < $past(s.gain) |-> s.gain >= $past(ceil_live))
        else $error("recovery passed ceiling");
    wait_rst_a: assert property (strobe && s.st == ALCV_ST_ACTIVE && en
        && !lim_hit && !quiet |=> s.wait_cnt == 11'h000)
        else $error("waiting timer not reset");
    leave_a: assert property (strobe && s.st == ALCV_ST_ACTIVE && !en
        |=> s.st == ALCV_ST_LEAVING)
        else $error("did not leave level control");
    manual_late_a: assert property ($rose(s.st == ALCV_ST_MANUAL)
        |-> $past(s.zc_cnt) + 11'h001 >= $past(zc_to))
        else $error("manual volume returned early");
    post_att_a: assert property (strobe && s.post_attenuation_sel == 2'h3
        |=> sample_out <= 16'sh0FFF && sample_out >= -16'sh1000)
        else $error("post attenuation missing");
    timeout_a: assert property (s.zc_cnt < 11'h400)
        else $error("zero-cross counter overran");

    lim_hit_c: cover property (strobe && s.st == ALCV_ST_ACTIVE && lim_hit);
    recover_c: cover property (s.st == ALCV_ST_ACTIVE ##1
        s.gain < $past(s.gain));
    leave_c: cover property ($rose(s.st == ALCV_ST_MANUAL));
    fast_c: cover property (s.st == ALCV_ST_ACTIVE && s.fast);
endmodule
